// ==== core/rmd_pkg.sv ====
// Shared constants and types for the register move datapath
package rmd_pkg;

  localparam int RMD_WORD = 32;
  localparam int RMD_DWORD = 64;
  localparam logic [7:0] RMD_FP_CC_COUNT = 8'h08;
  localparam logic [2:0] RMD_SELECT_NONE = 3'h0;
  localparam logic [1:0] RMD_FIRST_HIGH_RELEASE = 2'h2;
  localparam logic [31:0] RMD_ZERO_WORD = 32'h00000000;
  localparam logic [63:0] RMD_ACCUM_RESET = 64'h0000000000000000;
  localparam logic [31:0] RMD_HIGH_LSB = 32'h00000020;

  // Operation codes presented by the issue logic
  typedef enum logic [3:0]
  {
    RMD_OP_NONE,
    RMD_OP_READ_SYSTEM_COPROC,
    RMD_OP_READ_FLOAT_WORD,
    RMD_OP_READ_USER_COPROC,
    RMD_OP_READ_FLOAT_HIGH,
    RMD_OP_READ_USER_COPROC_HIGH,
    RMD_OP_READ_ACCUM_UPPER,
    RMD_OP_READ_ACCUM_LOWER,
    RMD_OP_FLOAT_REG_MOVE,
    RMD_OP_MOVE_ON_FP_FALSE,
    RMD_OP_MOVE_ON_NONZERO,
    RMD_OP_UNSIGNED_MULTIPLY_ACCUMULATE
  } rmd_op_e;

  // Float formats for the register move
  typedef enum logic [1:0]
  {
    RMD_FMT_SINGLE,
    RMD_FMT_DOUBLE,
    RMD_FMT_PAIRED_SINGLE,
    RMD_FMT_RESERVED
  } rmd_fmt_e;

endpackage

// ==== core/rmd_accum.sv ====
// Multiply accumulator pair with unsigned multiply-accumulate
`timescale 1ns/100ps
module rmd_accum
  import rmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic accumulate,
  input wire logic [31:0] operandA,
  input wire logic [31:0] operandB,
  output logic [31:0] accumUpper,
  output logic [31:0] accumLower
);

  typedef struct packed
  {
    logic [63:0] accum;
  } rmd_acc_s;

  rmd_acc_s state;
  rmd_acc_s next_state;

  // Unsigned product added to the concatenated pair
  always_comb
  begin
    next_state = state;
    if (accumulate)
    begin
      next_state.accum = state.accum + ({32'h00000000, operandA} * {32'h00000000, operandB});
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= '{accum: RMD_ACCUM_RESET};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign accumUpper = state.accum[63:32];
  assign accumLower = state.accum[31:0];

  a_acc_update: assert property (@(posedge clk_sys) disable iff (!resetn)
    accumulate |=> {accumUpper, accumLower} == $past({accumUpper, accumLower})
      + {32'h0, $past(operandA)} * {32'h0, $past(operandB)})
    else $error("accumulator sum wrong");
  a_acc_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !accumulate |=> $stable({accumUpper, accumLower}))
    else $error("accumulator changed without accumulate");

endmodule // rmd_accum

// ==== core/rmd_datapath.sv ====
// Register move datapath: coprocessor reads, accumulator reads, moves
`timescale 1ns/100ps
module rmd_datapath
  import rmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic issueValid,
  input wire rmd_op_e issueOp,
  input wire rmd_fmt_e floatFormat,
  input wire logic [4:0] targetField,
  input wire logic [4:0] floatSourceField,
  input wire logic [4:0] floatDestField,
  input wire logic [2:0] selectField,
  input wire logic [2:0] fpConditionIndex,
  input wire logic [31:0] sourceValue,
  input wire logic [31:0] testValue,
  input wire logic [31:0] systemCoprocData,
  input wire logic [63:0] floatSourceData,
  input wire logic [63:0] userCoprocData,
  input wire logic [7:0] fpConditionCodes,
  input wire logic fpuEnabled,
  input wire logic fpu64Bit,
  input wire logic floatRegisterModelFlag,
  input wire logic [1:0] archRelease,
  input wire logic pairedSingleSupported,
  output logic [4:0] systemCoprocNumber,
  output logic [2:0] systemCoprocSelect,
  output logic [4:0] floatSourceIndex,
  output logic [4:0] userCoprocIndex,
  output logic gprWriteValid,
  output logic [4:0] gprWriteIndex,
  output logic [31:0] gprWriteData,
  output logic fprWriteValid,
  output logic [4:0] fprWriteIndex,
  output logic [63:0] fprWriteData,
  output logic fpArithFlagWrite,
  output logic coprocUnusable,
  output logic reservedInstruction
);

  typedef struct packed
  {
    logic gprValid;
    logic [4:0] gprIndex;
    logic [31:0] gprData;
    logic fprValid;
    logic [4:0] fprIndex;
    logic [63:0] fprData;
    logic unusable;
    logic reserved;
  } rmd_dp_s;

  rmd_dp_s state;
  rmd_dp_s next_state;
  logic [31:0] accumUpper;
  logic [31:0] accumLower;
  logic accumulate;
  logic fpuOp;
  logic highOp;
  logic condFalse;

  // Register file reads are addressed straight from the issue fields
  assign systemCoprocNumber = floatSourceField;
  assign systemCoprocSelect = selectField;
  assign floatSourceIndex = floatSourceField;
  assign userCoprocIndex = floatSourceField;

  // Decode classes for exception checks, plus the false-condition test and the accumulate strobe
  assign fpuOp = issueOp == RMD_OP_READ_FLOAT_WORD || issueOp == RMD_OP_READ_FLOAT_HIGH
    || issueOp == RMD_OP_FLOAT_REG_MOVE || issueOp == RMD_OP_MOVE_ON_FP_FALSE;
  assign highOp = issueOp == RMD_OP_READ_FLOAT_HIGH || issueOp == RMD_OP_READ_USER_COPROC_HIGH;
  assign condFalse = !fpConditionCodes[fpConditionIndex];
  assign accumulate = issueValid && issueOp == RMD_OP_UNSIGNED_MULTIPLY_ACCUMULATE;

  // Accumulator reads are taken from the committed pair, so a following
  // accumulate cannot disturb a value already captured here
  rmd_accum u_accum
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .accumulate(accumulate),
    .operandA(sourceValue),
    .operandB(testValue),
    .accumUpper(accumUpper),
    .accumLower(accumLower)
  );

  // One-cycle result stage: decode, trap, select write data
  always_comb
  begin
    next_state = '0;
    next_state.gprIndex = targetField;
    next_state.fprIndex = floatDestField;
    if (issueValid)
    begin
      if (highOp && archRelease < RMD_FIRST_HIGH_RELEASE)
      begin
        next_state.reserved = 1'b1;
      end
      else if (fpuOp && !fpuEnabled)
      begin
        next_state.unusable = 1'b1;
      end
      else if (issueOp == RMD_OP_FLOAT_REG_MOVE && (floatFormat == RMD_FMT_RESERVED
        || (floatFormat == RMD_FMT_PAIRED_SINGLE && !pairedSingleSupported)))
      begin
        next_state.reserved = 1'b1;
      end
      else
      begin
        case (issueOp)
          RMD_OP_READ_SYSTEM_COPROC:
          begin
            // Unknown number/select pairs return whatever the bank drives
            next_state.gprValid = 1'b1;
            next_state.gprData = systemCoprocData;
          end
          RMD_OP_READ_FLOAT_WORD:
          begin
            next_state.gprValid = 1'b1;
            next_state.gprData = floatSourceData[31:0];
          end
          RMD_OP_READ_USER_COPROC:
          begin
            next_state.gprValid = 1'b1;
            next_state.gprData = userCoprocData[31:0];
          end
          RMD_OP_READ_FLOAT_HIGH:
          begin
            next_state.gprValid = 1'b1;
            next_state.gprData = floatSourceData[63:32];
          end
          RMD_OP_READ_USER_COPROC_HIGH:
          begin
            next_state.gprValid = 1'b1;
            next_state.gprData = userCoprocData[63:32];
          end
          RMD_OP_READ_ACCUM_UPPER:
          begin
            next_state.gprValid = 1'b1;
            next_state.gprData = accumUpper;
          end
          RMD_OP_READ_ACCUM_LOWER:
          begin
            next_state.gprValid = 1'b1;
            next_state.gprData = accumLower;
          end
          RMD_OP_FLOAT_REG_MOVE:
          begin
            // Whole 64 bits moved raw; a paired move outside the 64-bit,
            // flag-set model still copies but the result is not defined
            next_state.fprValid = 1'b1;
            next_state.fprData = floatSourceData;
          end
          RMD_OP_MOVE_ON_FP_FALSE:
          begin
            next_state.gprValid = condFalse;
            next_state.gprData = sourceValue;
          end
          RMD_OP_MOVE_ON_NONZERO:
          begin
            next_state.gprValid = testValue != RMD_ZERO_WORD;
            next_state.gprData = sourceValue;
          end
          default:
          begin
            next_state.gprValid = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign gprWriteValid = state.gprValid;
  assign gprWriteIndex = state.gprIndex;
  assign gprWriteData = state.gprData;
  assign fprWriteValid = state.fprValid;
  assign fprWriteIndex = state.fprIndex;
  assign fprWriteData = state.fprData;
  assign coprocUnusable = state.unusable;
  assign reservedInstruction = state.reserved;
  // Moves never touch the arithmetic cause or flag bits
  assign fpArithFlagWrite = 1'b0;

  a_sys_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_READ_SYSTEM_COPROC |=> gprWriteValid
      && gprWriteData == $past(systemCoprocData))
    else $error("system coprocessor read wrong");
  a_sys_target: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_READ_SYSTEM_COPROC |=>
      gprWriteIndex == $past(targetField))
    else $error("system coprocessor read wrong target");
  a_float_word: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_READ_FLOAT_WORD && fpuEnabled |=>
      gprWriteData == $past(floatSourceData[31:0]))
    else $error("float word read wrong");
  a_fpu_unusable: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && fpuOp && !fpuEnabled && !highOp |=> coprocUnusable && !gprWriteValid
      && !fprWriteValid)
    else $error("disabled fpu did not trap");
  a_float_reserved: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_FLOAT_REG_MOVE && fpuEnabled
      && floatFormat == RMD_FMT_RESERVED |=> reservedInstruction && !fprWriteValid)
    else $error("reserved float format not trapped");
  a_user_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_READ_USER_COPROC |=>
      gprWriteData == $past(userCoprocData[31:0]))
    else $error("user coprocessor read wrong");
  a_float_high: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_READ_FLOAT_HIGH && fpuEnabled
      && archRelease >= RMD_FIRST_HIGH_RELEASE |=>
      gprWriteValid && gprWriteData == $past(floatSourceData[63:32]))
    else $error("float high read wrong");
  a_old_release: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && highOp && archRelease < RMD_FIRST_HIGH_RELEASE |=>
      reservedInstruction && !gprWriteValid)
    else $error("high read not reserved");
  a_user_high: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_READ_USER_COPROC_HIGH
      && archRelease >= RMD_FIRST_HIGH_RELEASE |=>
      gprWriteData == $past(userCoprocData[63:32]))
    else $error("user high read wrong");
  a_accum_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_READ_ACCUM_UPPER |=> gprWriteData == $past(accumUpper)
      && !coprocUnusable && !reservedInstruction)
    else $error("accumulator read wrong");
  a_accum_lower: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_READ_ACCUM_LOWER |=> gprWriteValid
      && gprWriteData == $past(accumLower) && !coprocUnusable && !reservedInstruction)
    else $error("accumulator lower read wrong");
  a_float_move: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_FLOAT_REG_MOVE && fpuEnabled
      && floatFormat != RMD_FMT_RESERVED && floatFormat != RMD_FMT_PAIRED_SINGLE |=>
      fprWriteValid && fprWriteData == $past(floatSourceData)
      && fprWriteIndex == $past(floatDestField))
    else $error("float move wrong");
  // Only the 64-bit, flag-set model promises a defined paired result
  a_paired_move: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_FLOAT_REG_MOVE && fpuEnabled && fpu64Bit
      && floatRegisterModelFlag && floatFormat == RMD_FMT_PAIRED_SINGLE
      && pairedSingleSupported |=> fprWriteValid
      && fprWriteData == $past(floatSourceData))
    else $error("paired move did not copy both halves");
  a_no_flags: assert property (@(posedge clk_sys) disable iff (!resetn)
    !fpArithFlagWrite)
    else $error("move touched fp flags");
  a_fp_false: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_MOVE_ON_FP_FALSE && fpuEnabled |=>
      gprWriteValid == !$past(fpConditionCodes[fpConditionIndex]))
    else $error("fp false move wrong");
  a_nonzero: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_MOVE_ON_NONZERO |=>
      gprWriteValid == ($past(testValue) != 32'h0) && !coprocUnusable)
    else $error("nonzero move wrong");
  a_move_data: assert property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && (issueOp == RMD_OP_MOVE_ON_NONZERO
      || issueOp == RMD_OP_MOVE_ON_FP_FALSE && fpuEnabled) |=>
      gprWriteData == $past(sourceValue))
    else $error("conditional move data wrong");

  c_fp_false_taken: cover property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_MOVE_ON_FP_FALSE && fpuEnabled ##1 gprWriteValid);
  c_nonzero_skipped: cover property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_MOVE_ON_NONZERO && testValue == 32'h0);
  c_accum_then_read: cover property (@(posedge clk_sys) disable iff (!resetn)
    accumulate ##1 issueValid && issueOp == RMD_OP_READ_ACCUM_LOWER);
  c_unusable: cover property (@(posedge clk_sys) disable iff (!resetn) coprocUnusable);
  c_paired_move: cover property (@(posedge clk_sys) disable iff (!resetn)
    issueValid && issueOp == RMD_OP_FLOAT_REG_MOVE && floatFormat == RMD_FMT_PAIRED_SINGLE);

endmodule // rmd_datapath

// ==== tb/rmd_coproc_model.sv ====
// Behavioural coprocessor register files answering the datapath's read addresses
`timescale 1ns/100ps
module rmd_coproc_model
(
  input wire logic [4:0] systemCoprocNumber,
  input wire logic [2:0] systemCoprocSelect,
  input wire logic [4:0] floatSourceIndex,
  input wire logic [4:0] userCoprocIndex,
  output logic [31:0] systemCoprocData,
  output logic [63:0] floatSourceData,
  output logic [63:0] userCoprocData
);
  // Each register holds a pattern built from its own address, so a wrong index shows up
  // Every address answers, so missing registers simply return a pattern too
  assign systemCoprocData = {8'hA5, systemCoprocNumber, systemCoprocSelect, 16'h3C96};
  assign floatSourceData = {3'h5, floatSourceIndex, 24'hE1D2C3, 3'h2, floatSourceIndex, 24'h0F1E2D};
  assign userCoprocData = {userCoprocIndex, 27'h5AA5A5A, ~userCoprocIndex, 27'h12345AB};
endmodule // rmd_coproc_model

// ==== tb/tb.sv ====
// Self-checking random bench for the register move datapath
`timescale 1ns/100ps
module tb
  import rmd_pkg::*;
;
  typedef struct packed
  {
    logic gv;
    logic [4:0] gi;
    logic [31:0] gd;
    logic fv;
    logic [4:0] fi;
    logic [63:0] fd;
    logic cu;
    logic ri;
  } rmd_tb_exp_s;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic issueValid = 1'b0;
  rmd_op_e issueOp = RMD_OP_NONE;
  rmd_fmt_e floatFormat = RMD_FMT_SINGLE;
  logic [4:0] targetField = 5'h00, floatSourceField = 5'h00, floatDestField = 5'h00;
  logic [2:0] selectField = 3'h0, fpConditionIndex = 3'h0, systemCoprocSelect;
  logic [31:0] sourceValue = 32'h0, testValue = 32'h0, systemCoprocData, gprWriteData;
  logic [63:0] floatSourceData, userCoprocData, fprWriteData, acc = 64'h0;
  logic [7:0] fpConditionCodes = 8'h00;
  logic fpuEnabled = 1'b0, fpu64Bit = 1'b0, floatRegisterModelFlag = 1'b0;
  logic pairedSingleSupported = 1'b0;
  logic [1:0] archRelease = 2'h0;
  logic [4:0] systemCoprocNumber, floatSourceIndex, userCoprocIndex, gprWriteIndex, fprWriteIndex;
  logic gprWriteValid, fprWriteValid, fpArithFlagWrite, coprocUnusable, reservedInstruction;
  integer seed = 32'h02A9;
  int errorCnt = 0;
  int checksDone = 0;
  rmd_op_e accSeq [5] = '{RMD_OP_UNSIGNED_MULTIPLY_ACCUMULATE, RMD_OP_UNSIGNED_MULTIPLY_ACCUMULATE,
    RMD_OP_READ_ACCUM_UPPER, RMD_OP_UNSIGNED_MULTIPLY_ACCUMULATE, RMD_OP_READ_ACCUM_LOWER};

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  rmd_datapath uut (.clk_sys, .resetn, .issueValid, .issueOp, .floatFormat, .targetField,
    .floatSourceField, .floatDestField, .selectField, .fpConditionIndex, .sourceValue,
    .testValue, .systemCoprocData, .floatSourceData, .userCoprocData, .fpConditionCodes,
    .fpuEnabled, .fpu64Bit, .floatRegisterModelFlag, .archRelease, .pairedSingleSupported,
    .systemCoprocNumber, .systemCoprocSelect, .floatSourceIndex, .userCoprocIndex,
    .gprWriteValid, .gprWriteIndex, .gprWriteData, .fprWriteValid, .fprWriteIndex,
    .fprWriteData, .fpArithFlagWrite, .coprocUnusable, .reservedInstruction);
  rmd_coproc_model model (.systemCoprocNumber, .systemCoprocSelect, .floatSourceIndex,
    .userCoprocIndex, .systemCoprocData, .floatSourceData, .userCoprocData);

  // Expected register contents, mirroring the patterns the far side holds
  function automatic logic [31:0] sysVal(logic [4:0] n, logic [2:0] s);
    return {8'hA5, n, s, 16'h3C96};
  endfunction
  function automatic logic [63:0] fltVal(logic [4:0] i);
    return {3'h5, i, 24'hE1D2C3, 3'h2, i, 24'h0F1E2D};
  endfunction
  function automatic logic [63:0] usrVal(logic [4:0] i);
    return {i, 27'h5AA5A5A, ~i, 27'h12345AB};
  endfunction

  task automatic wrapUp();
    $display("checks %0d, mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chkFlag(logic got, logic expv);
    checksDone++;
    if (got !== expv)
    begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, expv);
    end
  endtask

  task automatic chkData(logic [63:0] got, logic [63:0] expv);
    checksDone++;
    if (got !== expv)
    begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, expv);
    end
  endtask

  // Works out the outcome of the instruction now on the inputs; trap checks go first
  task automatic predict(output rmd_tb_exp_s e);
    logic hi;
    logic fpuOp;
    e = '0;
    e.gi = targetField;
    e.fi = floatDestField;
    hi = issueOp inside {RMD_OP_READ_FLOAT_HIGH, RMD_OP_READ_USER_COPROC_HIGH};
    fpuOp = issueOp inside {RMD_OP_READ_FLOAT_WORD, RMD_OP_READ_FLOAT_HIGH,
      RMD_OP_FLOAT_REG_MOVE, RMD_OP_MOVE_ON_FP_FALSE};
    if (!issueValid)
      return;
    if (hi && archRelease < RMD_FIRST_HIGH_RELEASE)
      e.ri = 1'b1;
    else if (fpuOp && !fpuEnabled)
      e.cu = 1'b1;
    else if (issueOp == RMD_OP_FLOAT_REG_MOVE && (floatFormat == RMD_FMT_RESERVED
        || floatFormat == RMD_FMT_PAIRED_SINGLE && !pairedSingleSupported))
      e.ri = 1'b1;
    else
    begin
      case (issueOp)
        RMD_OP_READ_SYSTEM_COPROC: e.gd = sysVal(floatSourceField, selectField);
        RMD_OP_READ_FLOAT_WORD: e.gd = 32'(fltVal(floatSourceField));
        RMD_OP_READ_USER_COPROC: e.gd = 32'(usrVal(floatSourceField));
        RMD_OP_READ_FLOAT_HIGH: e.gd = 32'(fltVal(floatSourceField) >> 32);
        RMD_OP_READ_USER_COPROC_HIGH: e.gd = 32'(usrVal(floatSourceField) >> 32);
        RMD_OP_READ_ACCUM_UPPER: e.gd = acc[63:32];
        RMD_OP_READ_ACCUM_LOWER: e.gd = acc[31:0];
        default: e.gd = sourceValue;
      endcase
      e.gv = !(issueOp inside {RMD_OP_NONE, RMD_OP_FLOAT_REG_MOVE,
        RMD_OP_UNSIGNED_MULTIPLY_ACCUMULATE})
        && !(issueOp == RMD_OP_MOVE_ON_FP_FALSE && fpConditionCodes[fpConditionIndex])
        && !(issueOp == RMD_OP_MOVE_ON_NONZERO && testValue == RMD_ZERO_WORD);
      e.fv = issueOp == RMD_OP_FLOAT_REG_MOVE;
      e.fd = fltVal(floatSourceField);
      if (issueOp == RMD_OP_UNSIGNED_MULTIPLY_ACCUMULATE)
        acc = acc + 64'(sourceValue) * 64'(testValue);
    end
  endtask

  // Random values for every input; selects stay zero half the time as issuers must allow
  task automatic shake();
    issueValid = ({$random(seed)} % 8) != 0;
    issueOp = rmd_op_e'(4'({$random(seed)} % 12));
    floatFormat = rmd_fmt_e'(2'($random(seed)));
    targetField = 5'($random(seed));
    floatSourceField = 5'($random(seed));
    floatDestField = 5'($random(seed));
    selectField = ($random(seed) & 1) ? 3'($random(seed)) : RMD_SELECT_NONE;
    fpConditionIndex = 3'($random(seed));
    fpConditionCodes = 8'($random(seed));
    sourceValue = $random(seed);
    testValue = ($random(seed) & 1) ? $random(seed) : RMD_ZERO_WORD;
    fpuEnabled = ({$random(seed)} % 6) != 0;
    {fpu64Bit, floatRegisterModelFlag, pairedSingleSupported, archRelease} = 5'($random(seed));
  endtask

  // One issue cycle; the result is compared one cycle later, back to back
  task automatic step();
    rmd_tb_exp_s e;
    if (floatFormat == RMD_FMT_PAIRED_SINGLE)
      {fpu64Bit, floatRegisterModelFlag} = 2'h3;
    if (issueOp == RMD_OP_FLOAT_REG_MOVE && !fpuEnabled)
      floatFormat = RMD_FMT_DOUBLE;
    // Issuer keeps float register fields even in the 32-bit register model
    if (issueOp == RMD_OP_FLOAT_REG_MOVE && !floatRegisterModelFlag)
    begin
      floatSourceField[0] = 1'b0;
      floatDestField[0] = 1'b0;
    end
    predict(e);
    @(negedge clk_sys);
    chkFlag(gprWriteValid, e.gv);
    if (e.gv)
      chkData({27'h0, gprWriteIndex, gprWriteData}, {27'h0, e.gi, e.gd});
    chkFlag(fprWriteValid, e.fv);
    if (e.fv)
      chkData(fprWriteData ^ 64'(fprWriteIndex), e.fd ^ 64'(e.fi));
    chkFlag(coprocUnusable, e.cu);
    chkFlag(reservedInstruction, e.ri);
    chkFlag(fpArithFlagWrite, 1'b0);
  endtask

  task automatic runOp(rmd_op_e op, logic [1:0] rel, logic fpu, rmd_fmt_e fmt, logic [31:0] b);
    shake();
    issueValid = 1'b1;
    issueOp = op;
    archRelease = rel;
    fpuEnabled = fpu;
    floatFormat = fmt;
    sourceValue = 32'hFFFFFFFF;
    testValue = b;
    step();
  endtask

  // Cuts a hang short
  initial
  begin
    #200000;
    errorCnt++;
    wrapUp();
  end

  // Main sequence: corner cases first, then a long random run, then a reset followed by accumulator reads
  initial
  begin
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    foreach (accSeq[i])
      runOp(accSeq[i], 2'h2, 1'b1, RMD_FMT_SINGLE, 32'hFFFFFFFF);
    $display("test accum done, checks %0d", checksDone);
    for (int r = 0; r < 8; r++)
      runOp(r[0] ? RMD_OP_READ_FLOAT_HIGH : RMD_OP_READ_USER_COPROC_HIGH, 2'(r / 2), 1'b1,
        RMD_FMT_SINGLE, 32'h0);
    $display("test high done, checks %0d", checksDone);
    for (int k = 0; k < 24; k++)
      runOp(rmd_op_e'(4'(k % 12)), 2'h3, 1'(k / 12), RMD_FMT_SINGLE, 32'(k % 2));
    for (int k = 0; k < 16; k++)
      runOp(RMD_OP_FLOAT_REG_MOVE, 2'h2, 1'b1, rmd_fmt_e'(2'(k)), 32'h1);
    $display("test traps done, checks %0d", checksDone);
    repeat (3000)
    begin
      shake();
      step();
    end
    $display("test random done, checks %0d", checksDone);
    issueValid = 1'b0;
    resetn = 1'b0;
    acc = RMD_ACCUM_RESET;
    #1;
    chkFlag(gprWriteValid | fprWriteValid | coprocUnusable | reservedInstruction, 1'b0);
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    runOp(RMD_OP_READ_ACCUM_UPPER, 2'h2, 1'b1, RMD_FMT_SINGLE, 32'h0);
    runOp(RMD_OP_READ_ACCUM_LOWER, 2'h2, 1'b1, RMD_FMT_SINGLE, 32'h0);
    issueValid = 1'b0;
    $display("test reset done, checks %0d", checksDone);
    wrapUp();
  end
endmodule // tb
